// ---- design/lmt_pkg.sv ----
// Purpose: Shared constants and carrier types for the link message transmit control block.
// Assumes: Register indexes sit on 32-bit Wishbone words, byte address = 4 * index.
// Notes:   The link byte period is 1 ms / 4, and bits go out at an eighth of it.
package lmt_pkg;

   // Register indexes; the byte address on the bus is four times the index.
   localparam logic [7:0] IDX_MODE     = 8'h00;
   localparam logic [7:0] IDX_CTRL     = 8'h01;
   localparam logic [7:0] IDX_STATUS   = 8'h12;
   localparam logic [7:0] IDX_BUF_LO   = 8'h30;
   localparam logic [7:0] IDX_BUF_HI   = 8'h37;

   // Mode register fields.
   localparam int MODE_IRQ_EN_BIT = 0;   // parity_mode_irq_enable
   localparam int MODE_E3_BIT     = 1;   // E3 framing mode
   localparam logic [7:0] MODE_RESET = 8'h00;

   // Link control register fields.
   localparam int CTRL_SEND_BIT  = 0;    // send_message_bit
   localparam int CTRL_FCS_BIT   = 1;    // append_check_seq_bit
   localparam int CTRL_ABORT_BIT = 2;    // abort_message_bit
   localparam int CTRL_PTR_LSB   = 3;    // buffer_pointer_field [5:3]
   localparam int CTRL_DIS_BIT   = 6;    // link transmit disable
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Status register field.
   localparam int STAT_TX_IRQ_BIT = 3;   // tx_link_irq_flag

   // Line patterns, held so that bit 0 goes out first.
   localparam logic [7:0] IDLE_FLAG  = 8'h7e;
   localparam logic [7:0] ABORT_FLAG = 8'h7f;
   localparam logic [7:0] ALL_ONES   = 8'hff;

   // Check sequence: reflected CCITT polynomial, preset to all ones.
   localparam logic [15:0] CRC_POLY   = 16'h8408;
   localparam logic [15:0] CRC_PRESET = 16'hffff;

   // Timing: 1 ms holds 4 byte periods; 8 bits per byte.
   localparam int SERVICE_TIME_US   = 1000;
   localparam int BYTES_PER_SERVICE = 4;
   localparam int CLK_PERIOD_NS     = 10;
   localparam int BYTE_CYCLES       = (SERVICE_TIME_US * 1000 / BYTES_PER_SERVICE) / CLK_PERIOD_NS;
   localparam int BIT_CYCLES        = BYTE_CYCLES / 8;

   // Transmit sequencer states.
   typedef enum logic [2:0] {ST_IDLE, ST_DATA, ST_FCS, ST_FLAG, ST_ABORT, ST_OFF} lmt_state_e;

   // Wishbone classic request and response.
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [9:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } lmt_wb_req_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } lmt_wb_rsp_s;

endpackage : lmt_pkg

// ---- design/lmt_tx_ctrl.sv ----
// Purpose: Link message transmit control: buffer, control word, sequencer and interrupt.
// Assumes: One 100 MHz clock, synchronous active-high reset, classic Wishbone slave.
// Notes:   Zero stuffing is not performed; bytes leave the shifter verbatim.
//          Control changes act only at byte boundaries, so the host has a whole
//          byte period of slack after each interrupt before a word is taken.
//          An abort written and withdrawn inside one byte is remembered, so a
//          second control word may follow the abort at once.
//          A host that misses the service time finds the current word reused.
//          The interrupt pin is gated by mode bit 0 only, in either framing mode.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps

module lmt_tx_ctrl #(
   parameter int BIT_CYCLES = lmt_pkg::BIT_CYCLES   // Clock cycles per link bit.
) (
   input  wire logic                 clk_i,          // System clock.
   input  wire logic                 rst_i,          // Synchronous reset, active high.
   input  wire lmt_pkg::lmt_wb_req_s wb_req_i,       // Wishbone request.
   output      lmt_pkg::lmt_wb_rsp_s wb_rsp_o,       // Wishbone response.
   output      logic                 link_bit_o,     // Serial link bit, from a flip-flop.
   output      logic                 link_bit_stb_o, // Pulse when a new link bit starts.
   output      logic                 link_irq_pin_n_o // Link interrupt, active low level.
);
   import lmt_pkg::*;

   // Counter width; a bit period of up to about sixteen million clocks fits.
   localparam int CW = 24;

   // Refuse a bit period the counter cannot hold.
   if (BIT_CYCLES < 1 || BIT_CYCLES >= (1 << CW)) begin : g_bad_bit_cycles
      $error("BIT_CYCLES out of range");
   end

   // The buffer decode relies on eight entries starting on an eight-aligned index.
   if (IDX_BUF_HI - IDX_BUF_LO != 8'h07 || IDX_BUF_LO[2:0] != 3'h0) begin : g_bad_buf_map
      $error("buffer index range must be eight aligned entries");
   end

   // Last count of a bit period.
   localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);

   // All state lives in one record: bus answer, registers, buffer, interrupt flag,
   // sequencer position, check sequence and bit shifter. The shifter holds only the
   // seven bits still to go; bit 0 of a byte is on the line as soon as it loads.
   typedef struct packed {
      logic              ack;
      logic [31:0]       rdat;
      logic [7:0]        mode;
      logic [7:0]        ctrl;
      logic [7:0][7:0]   buf_mem;
      logic              tx_irq;
      logic              abort_pend;
      lmt_state_e        state;
      logic              cur_half;
      logic [1:0]        cur_stop;
      logic              cur_fcs;
      logic [1:0]        idx;
      logic              fcs_second;
      logic [15:0]       crc;
      logic              is_data;
      logic [CW-1:0]     cyc_cnt;
      logic [2:0]        bit_idx;
      logic [6:0]        shreg;
      logic              line;
      logic              tick;
   } lmt_regs_s;

   // Present and next state.
   lmt_regs_s s_q;
   lmt_regs_s s_d;

   // Decode helpers and the byte chosen at a boundary.
   logic       bus_req;
   logic       wr_now;
   logic [7:0] ridx;
   logic [7:0] wbyte;
   logic       link_on;
   logic       tick;
   logic       latch;
   logic [7:0] nb;
   logic       nb_data;
   logic [2:0] ptr;
   logic       abort_set;
   logic       abort_now;

   // Bus decode helpers; only byte lane 0 carries register data.
   assign bus_req = wb_req_i.cyc & wb_req_i.stb;
   // A write lands on the edge where the master sees ack, never earlier.
   assign wr_now  = bus_req & wb_req_i.we & s_q.ack & wb_req_i.sel[0];
   assign ridx    = wb_req_i.adr[9:2];
   assign wbyte   = wb_req_i.dat[7:0];
   assign ptr     = s_q.ctrl[CTRL_PTR_LSB +: 3];
   assign link_on = (s_q.mode[MODE_IRQ_EN_BIT] | s_q.mode[MODE_E3_BIT]) & ~s_q.ctrl[CTRL_DIS_BIT];
   assign tick    = (s_q.cyc_cnt == BIT_LAST);

   // An abort bit seen on any committed control write is kept until the next byte
   // boundary; without it a quick follow-up word would cancel the abort unseen.
   assign abort_set = wr_now & (ridx == IDX_CTRL) & wbyte[CTRL_ABORT_BIT];
   assign abort_now = s_q.ctrl[CTRL_ABORT_BIT] | s_q.abort_pend;

   // The sequencer walks idle flags, data, two check bytes, a closing flag and abort
   // flags. Every decision is taken when bit 7 of a byte has been on the line for a
   // full bit period, so the next byte is loaded and its first bit driven on the
   // same edge; the line never shows a half byte.
   // Bus decode, byte sequencer, check sequence and interrupt flag.
   always_comb begin
      s_d     = s_q;
      latch   = 1'b0;
      nb      = IDLE_FLAG;
      nb_data = 1'b0;

      // Single-wait-state slave: ack one cycle after the request, dropped after one.
      s_d.ack  = bus_req & ~s_q.ack;
      s_d.rdat = 32'h0000_0000;
      // Read data is taken in the request cycle and shown only while ack stands.
      if (bus_req & ~s_q.ack & ~wb_req_i.we) begin
         if (ridx == IDX_MODE) begin
            s_d.rdat[7:0] = s_q.mode;
         end else if (ridx == IDX_CTRL) begin
            s_d.rdat[7:0] = s_q.ctrl;
         end else if (ridx == IDX_STATUS) begin
            s_d.rdat[STAT_TX_IRQ_BIT] = s_q.tx_irq;
         end else if (ridx >= IDX_BUF_LO && ridx <= IDX_BUF_HI) begin
            s_d.rdat[7:0] = s_q.buf_mem[ridx[2:0]];
         end
      end
      // Writes to the status register and to unmapped indexes are dropped.
      if (wr_now) begin
         if (ridx == IDX_MODE) begin
            s_d.mode = wbyte;
         end else if (ridx == IDX_CTRL) begin
            s_d.ctrl   = wbyte;
            s_d.tx_irq = 1'b0;
         end else if (ridx >= IDX_BUF_LO && ridx <= IDX_BUF_HI) begin
            s_d.buf_mem[ridx[2:0]] = wbyte;
         end
      end

      // Bit timing.
      // The counter runs even with the link off, so the boundary grid never shifts.
      s_d.cyc_cnt = tick ? '0 : s_q.cyc_cnt + CW'(1);
      s_d.tick    = tick;

      if (tick && s_q.bit_idx == 3'd7) begin
         // Byte boundary: choose what the next byte is.
         // A message cut by the link going off is dropped; with send still set its block restarts straight after the all-ones bytes.
         if (!link_on) begin
            s_d.state = ST_OFF;
            nb        = ALL_ONES;
         end else begin
            case (s_q.state)
               // Data: finish the block, then check bytes, chain or idle.
               ST_DATA: begin
                  if (abort_now) begin
                     s_d.state = ST_ABORT;
                     nb        = ABORT_FLAG;
                  end else if (s_q.idx == s_q.cur_stop) begin
                     if (s_q.cur_fcs) begin
                        s_d.state      = ST_FCS;
                        s_d.fcs_second = 1'b0;
                        nb             = ~s_q.crc[7:0];
                     end else if (s_q.ctrl[CTRL_SEND_BIT]) begin
                        latch = 1'b1;
                     end else begin
                        s_d.state = ST_IDLE;
                        nb        = IDLE_FLAG;
                     end
                  end else begin
                     s_d.idx = s_q.idx + 2'd1;
                     nb      = s_q.buf_mem[{s_q.cur_half, s_d.idx}];
                     nb_data = 1'b1;
                  end
               end
               // Check bytes go out low byte first, inverted.
               ST_FCS: begin
                  if (abort_now) begin
                     s_d.state = ST_ABORT;
                     nb        = ABORT_FLAG;
                  end else if (!s_q.fcs_second) begin
                     s_d.fcs_second = 1'b1;
                     nb             = ~s_q.crc[15:8];
                  end else begin
                     s_d.state = ST_FLAG;
                     nb        = IDLE_FLAG;
                  end
               end
               // Abort flags repeat until the bit is withdrawn.
               ST_ABORT: begin
                  if (s_q.ctrl[CTRL_ABORT_BIT]) begin
                     nb = ABORT_FLAG;
                  end else if (s_q.ctrl[CTRL_SEND_BIT]) begin
                     s_d.state = ST_FLAG;
                     nb        = IDLE_FLAG;
                  end else begin
                     s_d.state = ST_IDLE;
                     nb        = IDLE_FLAG;
                  end
               end
               // Between messages a send word starts a new block and raises the interrupt.
               ST_IDLE, ST_FLAG, ST_OFF: begin
                  if (s_q.ctrl[CTRL_SEND_BIT] && !s_q.ctrl[CTRL_ABORT_BIT]) begin
                     latch   = 1'b1;
                     s_d.crc = CRC_PRESET;
                  end else begin
                     s_d.state = ST_IDLE;
                     nb        = IDLE_FLAG;
                  end
               end
               // Unreachable codes fall back to idle flags.
               default: begin
                  s_d.state = ST_IDLE;
                  nb        = IDLE_FLAG;
               end
            endcase
         end

         // Capture the control word and open the block it points at.
         // The interrupt set here wins over a control write in the same cycle.
         if (latch) begin
            s_d.state    = ST_DATA;
            s_d.cur_half = ptr[2];
            s_d.cur_stop = ptr[1:0];
            s_d.cur_fcs  = s_q.ctrl[CTRL_FCS_BIT];
            s_d.idx      = 2'd0;
            nb           = s_q.buf_mem[{ptr[2], 2'd0}];
            nb_data      = 1'b1;
            s_d.tx_irq   = 1'b1;
         end

         // Load the chosen byte; bit 0 goes on the line now, LSB first.
         s_d.is_data = nb_data;
         s_d.line    = nb[0];
         s_d.shreg   = nb[7:1];
         s_d.bit_idx = 3'd0;
      end else if (tick) begin
         s_d.line    = s_q.shreg[0];
         s_d.shreg   = {1'b1, s_q.shreg[6:1]};
         s_d.bit_idx = s_q.bit_idx + 3'd1;
      end

      // A pending abort is consumed at each boundary; one set in this cycle still wins.
      if (tick && s_q.bit_idx == 3'd7) begin
         s_d.abort_pend = abort_set;
      end else if (abort_set) begin
         s_d.abort_pend = 1'b1;
      end

      // Each data bit is folded into the check sequence as it goes on the line.
      // Flags, abort and check bytes are kept out, so the check covers data only.
      if (tick && s_d.is_data) begin
         s_d.crc = {1'b0, s_d.crc[15:1]} ^ ((s_d.crc[0] ^ s_d.line) ? CRC_POLY : 16'h0000);
      end
   end

   // State register; all-ones bytes go out from reset because the mode register is zero.
   // Bit 7 and a shifter of ones put the first boundary one bit period after reset.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q          <= '0;
         s_q.mode     <= MODE_RESET;
         s_q.ctrl     <= CTRL_RESET;
         s_q.state    <= ST_IDLE;
         s_q.crc      <= CRC_PRESET;
         s_q.bit_idx  <= 3'd7;
         s_q.shreg    <= 7'h7f;
         s_q.line     <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Every output but the interrupt pin comes straight from a register; the pin is a gate of two registers.
   assign wb_rsp_o.ack     = s_q.ack;
   assign wb_rsp_o.dat     = s_q.rdat;
   assign link_bit_o       = s_q.line;
   assign link_bit_stb_o   = s_q.tick;
   // Level output held until the control register is written; clearing mode bit 0 masks it meanwhile.
   assign link_irq_pin_n_o = ~(s_q.tx_irq & s_q.mode[MODE_IRQ_EN_BIT]);

endmodule : lmt_tx_ctrl

// ---- dv/lmt_host_model.sv ----
// Purpose: Host processor model issuing classic bus cycles.
// Assumes: Calls start right after a rising clock edge.
// Notes:   Waits for ack with no fixed latency; the bench timeout ends a hang.
`timescale 1ns/1ps
module lmt_host_model (
   input  wire logic                 clk_i, // Clock.
   input  wire lmt_pkg::lmt_wb_rsp_s rsp_i, // Slave response.
   output      lmt_pkg::lmt_wb_req_s req_o  // Master request.
);
   import lmt_pkg::*;
   initial req_o = '0;
   // One cycle, held to the ack edge; control writes service interrupts.
   task automatic xfer(input logic we, input logic [7:0] i, input logic [7:0] d,
                       output logic [7:0] q);
      req_o <= '{1'b1, 1'b1, we, {i, 2'b00}, 4'h1, {24'h0, d}};
      @(posedge clk_i);
      while (rsp_i.ack !== 1'b1) begin
         @(posedge clk_i);
      end
      q = rsp_i.dat[7:0];
      req_o <= '0;
      @(posedge clk_i);
   endtask : xfer
endmodule : lmt_host_model

// ---- dv/lmt_tx_ctrl_checker.sv ----
// Purpose: Concurrent checks on the transmit control ports.
// Assumes: The bind hands on BIT_CYCLES; the bench uses 4.
// Notes:   Mode bit 0 is mirrored from writes committed at the ack edge.
`timescale 1ns/1ps
module lmt_tx_ctrl_checker #(
   parameter int BIT_CYCLES = 4 // Cycles per link bit.
) (
   input wire logic                 clk_i,           // Clock.
   input wire logic                 rst_i,           // Reset.
   input wire lmt_pkg::lmt_wb_req_s wb_req_i,        // Bus request.
   input wire lmt_pkg::lmt_wb_rsp_s wb_rsp_o,        // Bus response.
   input wire logic                 link_bit_o,      // Link bit.
   input wire logic                 link_bit_stb_o,  // Bit strobe.
   input wire logic                 link_irq_pin_n_o // Interrupt pin.
);
   import lmt_pkg::*;
   logic en_q;
   logic ack;
   logic wr_ok;
   // Committed writes only; a write without lane 0 changes nothing.
   assign ack   = wb_rsp_o.ack;
   assign wr_ok = ack & wb_req_i.we & wb_req_i.sel[0];
   // Mirror of the enable, so the pin can be judged without peeking inside.
   always_ff @(posedge clk_i) begin
      if (rst_i)
         en_q <= 1'b0;
      else if (wr_ok && wb_req_i.adr[9:2] == IDX_MODE)
         en_q <= wb_req_i.dat[MODE_IRQ_EN_BIT];
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (wb_req_i.cyc && wb_req_i.stb && !ack |=> ack)
      else $error("no ack one cycle after request");
   AST_DAT_IDLE: assert property (!ack |-> wb_rsp_o.dat == '0)
      else $error("read data outside ack");
   AST_STAT_PIN: assert property (ack && !wb_req_i.we && $past(en_q)
      && wb_req_i.adr[9:2] == IDX_STATUS
      |-> wb_rsp_o.dat[STAT_TX_IRQ_BIT] != $past(link_irq_pin_n_o))
      else $error("status flag disagrees with pin");
   AST_IRQ_GATE: assert property (!en_q |-> link_irq_pin_n_o)
      else $error("pin low while disabled");
   AST_IRQ_HOLD: assert property (!link_irq_pin_n_o && !wr_ok |=> !link_irq_pin_n_o)
      else $error("pin released without a write");
   AST_IRQ_CLR: assert property (wr_ok && wb_req_i.adr[9:2] == IDX_CTRL
      |-> ##[1:2] (link_irq_pin_n_o || link_bit_stb_o))
      else $error("control write left pin low");
   AST_BIT_HOLD: assert property (!link_bit_stb_o |-> $stable(link_bit_o))
      else $error("link bit moved without strobe");
   AST_BIT_GAP: assert property (BIT_CYCLES >= 4 && link_bit_stb_o
      |=> !link_bit_stb_o [*3])
      else $error("strobes too close");
endmodule : lmt_tx_ctrl_checker

bind lmt_tx_ctrl lmt_tx_ctrl_checker #(.BIT_CYCLES(BIT_CYCLES)) u_lmt_tx_ctrl_checker (
   .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
   .link_bit_o(link_bit_o), .link_bit_stb_o(link_bit_stb_o),
   .link_irq_pin_n_o(link_irq_pin_n_o));

// ---- dv/tb_lmt_tx_ctrl.sv ----
// Purpose: Self-checking bench for the link message transmit control block.
// Assumes: Bit period of 4 clocks, so one link byte is 32 clocks.
// Notes:   Link bits are logged and searched for whole byte runs.
`timescale 1ns/1ps
module tb_lmt_tx_ctrl;
   import lmt_pkg::*;
   localparam int BC = 4;
   logic        clk_i, rst_i, bit_o, stb_o, irq_n;
   lmt_wb_req_s req;
   lmt_wb_rsp_s rsp;
   logic [7:0]  rd;
   logic [15:0] c1, c2;
   logic        bits[$];
   int          fail_count = 0, n_tests = 0, cyc_cnt = 0;

   lmt_tx_ctrl #(.BIT_CYCLES(BC)) u_lmt_tx_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
      .wb_rsp_o(rsp), .link_bit_o(bit_o), .link_bit_stb_o(stb_o), .link_irq_pin_n_o(irq_n));
   lmt_host_model u_lmt_host_model (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Log link bits; the ceiling is far above the few thousand cycles needed.
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (stb_o === 1'b1)
         bits.push_back(bit_o);
      if (cyc_cnt == 20000) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      u_lmt_host_model.xfer(1'b1, i, d, rd);
   endtask : wr
   task automatic rdx(input logic [7:0] i);
      u_lmt_host_model.xfer(1'b0, i, 8'h00, rd);
   endtask : rdx
   task automatic wait_irq();
      for (int n = 0; n < 400 && irq_n !== 1'b0; n++)
         @(posedge clk_i);
      chk(irq_n === 1'b0, "no interrupt");
   endtask : wait_irq
   // Reflected check sequence, worked out here independently of the design.
   function automatic logic [15:0] crc(input logic [7:0] b[$]);
      logic [15:0] c = CRC_PRESET;
      foreach (b[i])
         for (int k = 0; k < 8; k++)
            c = (c >> 1) ^ ((c[0] ^ b[i][k]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction : crc
   // True if the bytes appear, LSB first, at any bit offset of the log.
   function automatic logic has(input logic [7:0] e[$]);
      logic ok;
      for (int i = 0; i + 8 * e.size() <= bits.size(); i++) begin
         ok = 1'b1;
         foreach (e[j])
            for (int k = 0; k < 8; k++)
               if (bits[i + 8 * j + k] !== e[j][k])
                  ok = 1'b0;
         if (ok)
            return 1'b1;
      end
      return 1'b0;
   endfunction : has
   task automatic finish_test();
      $display("checks %0d failures %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   initial begin
      rst_i = 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(irq_n === 1'b1 && bit_o === 1'b1, "reset levels");
      rdx(IDX_STATUS);
      chk(rd === 8'h00, "status after reset");
      wr(8'h20, 8'h5a);
      rdx(8'h20);
      chk(rd === 8'h00, "unmapped read");
      wr(IDX_MODE, 8'h01);
      repeat (64 * BC) @(posedge clk_i);
      chk(has({IDLE_FLAG, IDLE_FLAG, IDLE_FLAG}) && irq_n === 1'b1, "idle");
      $display("test idle done");
      for (int i = 0; i < 4; i++)
         wr(8'(IDX_BUF_LO + i), 8'ha1 + 8'(i));
      wr(IDX_CTRL, 8'h19);
      wait_irq();
      rdx(IDX_STATUS);
      chk(rd[STAT_TX_IRQ_BIT] === 1'b1, "status flag");
      wr(IDX_MODE, 8'h02);
      chk(irq_n === 1'b1, "pin gated");
      wr(IDX_MODE, 8'h01);
      chk(irq_n === 1'b0, "pin level held");
      wr(8'h34, 8'hb1);
      wr(8'h35, 8'hb2);
      wr(IDX_CTRL, 8'h2b);
      @(posedge clk_i);
      chk(irq_n === 1'b1, "pin cleared");
      rdx(IDX_STATUS);
      chk(rd[STAT_TX_IRQ_BIT] === 1'b0, "status cleared");
      wait_irq();
      wr(IDX_BUF_LO, 8'hc1);
      wr(IDX_CTRL, 8'h03);
      wait_irq();
      wr(IDX_CTRL, 8'h00);
      repeat (48 * BC) @(posedge clk_i);
      c1 = crc({8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'hb1, 8'hb2});
      c2 = crc({8'hc1});
      chk(has({IDLE_FLAG, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'hb1, 8'hb2, ~c1[7:0], ~c1[15:8],
         IDLE_FLAG, 8'hc1, ~c2[7:0], ~c2[15:8], IDLE_FLAG, IDLE_FLAG}), "chain");
      $display("test chain done");
      bits.delete();
      for (int i = 0; i < 4; i++)
         wr(8'(IDX_BUF_LO + i), 8'hd1 + 8'(i));
      wr(IDX_CTRL, 8'h19);
      wait_irq();
      wr(IDX_CTRL, 8'h1d);
      repeat (48 * BC) @(posedge clk_i);
      wr(IDX_CTRL, 8'h19);
      wait_irq();
      wr(IDX_CTRL, 8'h00);
      repeat (64 * BC) @(posedge clk_i);
      chk(has({8'hd1, ABORT_FLAG, ABORT_FLAG, ABORT_FLAG}), "abort");
      chk(has({ABORT_FLAG, IDLE_FLAG, 8'hd1, 8'hd2, 8'hd3, 8'hd4, IDLE_FLAG}), "restart");
      chk(irq_n === 1'b1, "quiet idle");
      $display("test abort done");
      bits.delete();
      wr(IDX_CTRL, 8'h19);
      wait_irq();
      wr(IDX_CTRL, 8'h1d);
      wr(IDX_CTRL, 8'h19);
      wait_irq();
      wr(IDX_CTRL, 8'h00);
      repeat (64 * BC) @(posedge clk_i);
      chk(has({8'hd1, ABORT_FLAG, IDLE_FLAG, 8'hd1, 8'hd2, 8'hd3, 8'hd4, IDLE_FLAG}),
         "quick abort");
      $display("test quick abort done");
      bits.delete();
      wr(IDX_CTRL, 8'h40);
      repeat (40 * BC) @(posedge clk_i);
      chk(has({ALL_ONES, ALL_ONES, ALL_ONES}) && irq_n === 1'b1, "disabled");
      $display("test disable done");
      finish_test();
   end
endmodule : tb_lmt_tx_ctrl
